/* File: verilog/coproc_cmd_pkg.sv */
// shared opcodes, layouts, reset values and timing counts for the command link
package coproc_cmd_pkg;
  localparam logic [31:0] OP_SET_ROTATE    = 32'hffffff36;
  localparam logic [31:0] OP_SPINNER       = 32'hffffff16;
  localparam logic [31:0] OP_SCREENSAVER   = 32'hffffff2f;
  localparam logic [31:0] OP_SKETCH        = 32'hffffff30;
  localparam logic [31:0] OP_STOP          = 32'hffffff17;
  localparam logic [31:0] OP_SET_FONT      = 32'hffffff2b;
  localparam logic [31:0] OP_SET_FONT_EXT  = 32'hffffff3b;
  localparam logic [31:0] OP_SET_SCRATCH   = 32'hffffff3c;
  // parameter words following each opcode that takes any
  localparam int          PW_SET_ROTATE    = 1;
  localparam int          PW_SPINNER       = 2;
  localparam int          PW_SKETCH        = 4;
  localparam int          PW_SET_FONT      = 2;
  localparam int          PW_SET_FONT_EXT  = 3;
  localparam int          PW_SET_SCRATCH   = 1;
  localparam logic [2:0]  ROTATE_MAX       = 3'h7;
  localparam logic [1:0]  SPIN_STYLE_MAX   = 2'h3;
  localparam logic [4:0]  SCRATCH_RESET    = 5'h0f;
  localparam logic [4:0]  HANDLE_MAX       = 5'h1f;
  localparam logic [31:0] one_bit_luma_format   = 32'h00000001;
  localparam logic [31:0] eight_bit_luma_format = 32'h00000003;
  // frames per spinner cycle at 60 fps: 2 s, 1.25 s, 2 s, 1 s
  localparam int          SPIN_FRAMES_S0   = 120;
  localparam int          SPIN_FRAMES_S1   = 75;
  localparam int          SPIN_FRAMES_S2   = 120;
  localparam int          SPIN_FRAMES_S3   = 60;
  localparam int          CLK_HZ           = 40000000;
  localparam int          FRAME_HZ         = 60;
  localparam int          TOUCH_HZ_MAX     = 1000;
  localparam int          FRAME_CYCLES     = CLK_HZ / FRAME_HZ;
  // least period for a 1000 Hz ceiling, rounded up
  localparam int          TOUCH_CYCLES     = (CLK_HZ + TOUCH_HZ_MAX - 1) / TOUCH_HZ_MAX;
  // vertex instruction opcode in bits 31:30
  localparam logic [1:0]  VERTEX_OP        = 2'h1;
  typedef enum logic [1:0] {TASK_NONE = 2'h0, TASK_SPIN = 2'h1,
                            TASK_SAVER = 2'h3, TASK_SKETCH = 2'h2} task_e;
endpackage : coproc_cmd_pkg

/* File: verilog/coproc_cmd_if.sv */
// word link from the host command writer to the co-processor
`timescale 1ns/1ps
interface coproc_cmd_if;
  logic        cmd_valid;
  logic [31:0] cmd_word;
  logic        cmd_ready;
  logic        cmd_idle;
  modport host   (output cmd_valid, output cmd_word, input cmd_ready, input cmd_idle);
  modport device (input cmd_valid, input cmd_word, output cmd_ready, output cmd_idle);
endinterface : coproc_cmd_if

/* File: verilog/coproc_cmd_engine.sv */
// co-processor end: decodes rotate, periodic task, font and scratch commands
`timescale 1ns/1ps
module coproc_cmd_engine #(
  parameter int FRAME_DIV = coproc_cmd_pkg::FRAME_CYCLES,
  parameter int TOUCH_DIV = coproc_cmd_pkg::TOUCH_CYCLES
) (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  // command link
  coproc_cmd_if.device     CMD,
  // touch input, from pins
  input  wire logic        TOUCH_VALID,
  input  wire logic [15:0] TOUCH_X,
  input  wire logic [15:0] TOUCH_Y,
  // display state
  output logic [2:0]       ROTATE,
  output logic [2:0]       TOUCH_ORIENT,
  output logic             DL_SWAP,
  output logic [31:0]      MACRO_SLOT_ZERO,
  output logic [31:0]      MACRO_SLOT_ONE,
  // sketch bitmap write
  output logic             PIX_WE,
  output logic [31:0]      PIX_ADDR,
  output logic [7:0]       PIX_DATA,
  // font, scratch and task state
  output logic             FONT_WE,
  output logic [4:0]       FONT_HANDLE,
  output logic [31:0]      FONT_METRICS,
  output logic [31:0]      FONT_FIRST_CHAR,
  output logic [4:0]       SCRATCH_HANDLE,
  output logic [1:0]       TASK_ACTIVE
);
  import coproc_cmd_pkg::*;

  // dividers below two are refused at elaboration
  if (FRAME_DIV < 2 || TOUCH_DIV < 2)
  begin : g_bad_div
    $error("divider too small");
  end

  typedef enum logic [1:0] {ST_OP = 2'h0, ST_PARAM = 2'h1} dec_e;
  dec_e        st_reg;
  logic [31:0] op_reg;
  logic [2:0]  idx_reg;
  logic [2:0]  need_reg;
  logic [31:0] p_reg [0:3];
  task_e       task_reg;
  logic        take;
  logic        last;
  logic [2:0]  need_next;

  assign take      = CMD.cmd_valid && CMD.cmd_ready;
  assign last      = take && (st_reg == ST_PARAM) && (idx_reg == need_reg - 3'h1);
  assign CMD.cmd_ready = 1'b1;

  always_comb
  begin
    need_next = 3'h0;
    if (CMD.cmd_word == OP_SET_ROTATE) need_next = 3'(PW_SET_ROTATE);
    else if (CMD.cmd_word == OP_SPINNER) need_next = 3'(PW_SPINNER);
    else if (CMD.cmd_word == OP_SKETCH) need_next = 3'(PW_SKETCH);
    else if (CMD.cmd_word == OP_SET_FONT) need_next = 3'(PW_SET_FONT);
    else if (CMD.cmd_word == OP_SET_FONT_EXT) need_next = 3'(PW_SET_FONT_EXT);
    else if (CMD.cmd_word == OP_SET_SCRATCH) need_next = 3'(PW_SET_SCRATCH);
  end

  // decoder: opcode, then its exact count of parameter words
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st_reg   <= ST_OP;
      op_reg   <= 32'h0;
      idx_reg  <= 3'h0;
      need_reg <= 3'h0;
    end
    else if (take)
    begin
      if (st_reg == ST_OP)
      begin
        op_reg   <= CMD.cmd_word;
        need_reg <= need_next;
        idx_reg  <= 3'h0;
        if (need_next != 3'h0) st_reg <= ST_PARAM;
      end
      else
      begin
        idx_reg <= idx_reg + 3'h1;
        if (last) st_reg <= ST_OP;
      end
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (take && st_reg == ST_PARAM) p_reg[idx_reg[1:0]] <= CMD.cmd_word;
  end

  // idle: no partial command held
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST) CMD.cmd_idle <= 1'b1;
    else CMD.cmd_idle <= !(take && (st_reg == ST_OP) && need_next != 3'h0)
                         && !(st_reg == ST_PARAM && !last);
  end

  // immediate commands
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ROTATE          <= 3'h0;
      TOUCH_ORIENT    <= 3'h0;
      FONT_WE         <= 1'b0;
      FONT_HANDLE     <= 5'h0;
      FONT_METRICS    <= 32'h0;
      FONT_FIRST_CHAR <= 32'h0;
      SCRATCH_HANDLE  <= SCRATCH_RESET;
    end
    else
    begin
      FONT_WE <= 1'b0;
      if (last && op_reg == OP_SET_ROTATE)
      begin
        ROTATE       <= CMD.cmd_word[2:0];
        TOUCH_ORIENT <= CMD.cmd_word[2:0];
      end
      if (last && (op_reg == OP_SET_FONT || op_reg == OP_SET_FONT_EXT))
      begin
        FONT_WE      <= 1'b1;
        FONT_HANDLE  <= p_reg[0][4:0];
        FONT_METRICS <= (op_reg == OP_SET_FONT) ? CMD.cmd_word : p_reg[1];
        FONT_FIRST_CHAR <= (op_reg == OP_SET_FONT_EXT) ? CMD.cmd_word : 32'h0;
      end
      if (last && op_reg == OP_SET_SCRATCH) SCRATCH_HANDLE <= CMD.cmd_word[4:0];
    end
  end

  // periodic task selection; a new start replaces any running one
  logic [15:0] sx_reg, sy_reg, sw_reg, sh_reg;
  logic [1:0]  style_reg;
  logic [15:0] scale_reg;
  logic [31:0] base_reg;
  logic        l8_reg;
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      task_reg  <= TASK_NONE;
      sx_reg    <= 16'h0;
      sy_reg    <= 16'h0;
      sw_reg    <= 16'h0;
      sh_reg    <= 16'h0;
      style_reg <= 2'h0;
      scale_reg <= 16'h0;
      base_reg  <= 32'h0;
      l8_reg    <= 1'b0;
    end
    else if (take && st_reg == ST_OP && CMD.cmd_word == OP_STOP) task_reg <= TASK_NONE;
    else if (take && st_reg == ST_OP && CMD.cmd_word == OP_SCREENSAVER)
      task_reg <= TASK_SAVER;
    else if (last && op_reg == OP_SPINNER)
    begin
      task_reg  <= TASK_SPIN;
      sx_reg    <= p_reg[0][15:0];
      sy_reg    <= p_reg[0][31:16];
      style_reg <= CMD.cmd_word[1:0];
      scale_reg <= CMD.cmd_word[31:16];
    end
    else if (last && op_reg == OP_SKETCH)
    begin
      task_reg <= TASK_SKETCH;
      sx_reg   <= p_reg[0][15:0];
      sy_reg   <= p_reg[0][31:16];
      sw_reg   <= p_reg[1][15:0];
      sh_reg   <= p_reg[1][31:16];
      base_reg <= p_reg[2];
      l8_reg   <= (CMD.cmd_word == eight_bit_luma_format);
    end
  end
  assign TASK_ACTIVE = task_reg;

  // frame and touch tick dividers, free running
  logic [31:0] fdiv_reg, tdiv_reg;
  logic        ftick, ttick;
  assign ftick = (fdiv_reg == 32'(FRAME_DIV - 1));
  assign ttick = (tdiv_reg == 32'(TOUCH_DIV - 1));
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      fdiv_reg <= 32'h0;
      tdiv_reg <= 32'h0;
    end
    else
    begin
      fdiv_reg <= ftick ? 32'h0 : fdiv_reg + 32'h1;
      tdiv_reg <= ttick ? 32'h0 : tdiv_reg + 32'h1;
    end
  end

  // animation: spinner phase and screensaver bounce
  logic [6:0]  phase_reg;
  logic [6:0]  plen;
  logic [15:0] vx_reg, vy_reg;
  logic        dx_reg, dy_reg;
  always_comb
  begin
    case (style_reg)
      2'h0:    plen = 7'(SPIN_FRAMES_S0);
      2'h1:    plen = 7'(SPIN_FRAMES_S1);
      2'h2:    plen = 7'(SPIN_FRAMES_S2);
      default: plen = 7'(SPIN_FRAMES_S3);
    endcase
  end
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      phase_reg       <= 7'h0;
      vx_reg          <= 16'h0;
      vy_reg          <= 16'h0;
      dx_reg          <= 1'b0;
      dy_reg          <= 1'b0;
      MACRO_SLOT_ZERO <= 32'h0;
      MACRO_SLOT_ONE  <= 32'h0;
      DL_SWAP         <= 1'b0;
    end
    else
    begin
      DL_SWAP <= last && op_reg == OP_SPINNER;
      if (task_reg == TASK_SPIN && ftick)
      begin
        phase_reg <= (phase_reg >= plen - 7'h1) ? 7'h0 : phase_reg + 7'h1;
        // scale zero keeps unit size
        MACRO_SLOT_ZERO <= {VERTEX_OP, 1'b0, sx_reg[13:0], 1'b0, sy_reg[13:0]};
        MACRO_SLOT_ONE  <= {scale_reg == 16'h0 ? 16'h1 : scale_reg,
                            5'h0, style_reg, 2'h0, phase_reg};
      end
      else if (task_reg == TASK_SAVER && ftick)
      begin
        vx_reg <= dx_reg ? vx_reg - 16'h1 : vx_reg + 16'h1;
        vy_reg <= dy_reg ? vy_reg - 16'h1 : vy_reg + 16'h1;
        if (vx_reg == 16'h01ff || (dx_reg && vx_reg == 16'h1)) dx_reg <= !dx_reg;
        if (vy_reg == 16'h00ff || (dy_reg && vy_reg == 16'h1)) dy_reg <= !dy_reg;
        MACRO_SLOT_ZERO <= {VERTEX_OP, 1'b0, vx_reg[13:0], 1'b0, vy_reg[13:0]};
      end
      else if (task_reg == TASK_NONE) phase_reg <= 7'h0;
    end
  end

  // sketch: touch pins synchronised before use
  logic        tv1_reg, tv2_reg;
  logic [15:0] tx1_reg, tx2_reg, ty1_reg, ty2_reg;
  logic [15:0] rx, ry;
  logic [31:0] off;
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      tv1_reg <= 1'b0;
      tv2_reg <= 1'b0;
      tx1_reg <= 16'h0;
      tx2_reg <= 16'h0;
      ty1_reg <= 16'h0;
      ty2_reg <= 16'h0;
    end
    else
    begin
      tv1_reg <= TOUCH_VALID;
      tv2_reg <= tv1_reg;
      tx1_reg <= TOUCH_X;
      tx2_reg <= tx1_reg;
      ty1_reg <= TOUCH_Y;
      ty2_reg <= ty1_reg;
    end
  end
  assign rx  = tx2_reg - sx_reg;
  assign ry  = ty2_reg - sy_reg;
  assign off = 32'(ry) * 32'(sw_reg) + 32'(rx);
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      PIX_WE   <= 1'b0;
      PIX_ADDR <= 32'h0;
      PIX_DATA <= 8'h0;
    end
    else
    begin
      // one pixel per touch sample, only inside the area
      PIX_WE <= task_reg == TASK_SKETCH && ttick && tv2_reg
                && tx2_reg >= sx_reg && rx < sw_reg
                && ty2_reg >= sy_reg && ry < sh_reg;
      PIX_ADDR <= base_reg + (l8_reg ? off : (off >> 3));
      PIX_DATA <= l8_reg ? 8'hff : (8'h80 >> off[2:0]);
    end
  end
endmodule : coproc_cmd_engine

/* File: verilog/coproc_cmd_host.sv */
// host end: serialises user commands into words for the co-processor
`timescale 1ns/1ps
module coproc_cmd_host (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  // user request: opcode and up to four parameter words
  input  wire logic        REQ_VALID,
  input  wire logic [31:0] REQ_OP,
  input  wire logic [2:0]  REQ_NWORDS,
  input  wire logic [31:0] REQ_P0,
  input  wire logic [31:0] REQ_P1,
  input  wire logic [31:0] REQ_P2,
  input  wire logic [31:0] REQ_P3,
  output logic             REQ_READY,
  output logic             REQ_DONE,
  // command link
  coproc_cmd_if.host       CMD
);
  import coproc_cmd_pkg::*;

  logic [31:0] w_reg [0:4];
  logic [2:0]  n_reg, i_reg;
  logic        busy_reg, wait_reg;

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      busy_reg      <= 1'b0;
      wait_reg      <= 1'b0;
      n_reg         <= 3'h0;
      i_reg         <= 3'h0;
      REQ_READY     <= 1'b1;
      REQ_DONE      <= 1'b0;
      CMD.cmd_valid <= 1'b0;
      CMD.cmd_word  <= 32'h0;
    end
    else
    begin
      REQ_DONE <= 1'b0;
      if (!busy_reg && !wait_reg && REQ_VALID && REQ_READY)
      begin
        w_reg[0] <= REQ_OP;
        // mask rotation to its low three bits before it leaves the host
        w_reg[1] <= (REQ_OP == OP_SET_ROTATE) ? {29'h0, REQ_P0[2:0]} : REQ_P0;
        w_reg[2] <= REQ_P1;
        w_reg[3] <= REQ_P2;
        w_reg[4] <= REQ_P3;
        n_reg    <= REQ_NWORDS;
        i_reg    <= 3'h0;
        busy_reg <= 1'b1;
        REQ_READY <= 1'b0;
      end
      else if (busy_reg)
      begin
        if (!CMD.cmd_valid || CMD.cmd_ready)
        begin
          if (CMD.cmd_valid && i_reg == n_reg + 3'h1)
          begin
            CMD.cmd_valid <= 1'b0;
            busy_reg      <= 1'b0;
            wait_reg      <= 1'b1;
          end
          else
          begin
            CMD.cmd_valid <= 1'b1;
            CMD.cmd_word  <= w_reg[i_reg];
            i_reg         <= i_reg + 3'h1;
            if (i_reg == n_reg)
            begin
              busy_reg <= 1'b0;
              wait_reg <= 1'b1;
            end
          end
        end
      end
      else if (wait_reg)
      begin
        if (CMD.cmd_valid && CMD.cmd_ready) CMD.cmd_valid <= 1'b0;
        else if (!CMD.cmd_valid && CMD.cmd_idle)
        begin
          wait_reg  <= 1'b0;
          REQ_DONE  <= 1'b1;
          REQ_READY <= 1'b1;
        end
      end
    end
  end
endmodule : coproc_cmd_host

/* File: verification/coproc_cmd_monitor.sv */
// link and engine state checks for the command interpreter
`timescale 1ns/1ps
module coproc_cmd_monitor (
  // clock and reset
  input wire logic        MCLK,
  input wire logic        SYS_RST,
  // command link
  input wire logic        cmd_valid,
  input wire logic [31:0] cmd_word,
  input wire logic        cmd_ready,
  input wire logic        cmd_idle,
  // engine state
  input wire logic [2:0]  ROTATE,
  input wire logic [2:0]  TOUCH_ORIENT,
  input wire logic        DL_SWAP,
  input wire logic [31:0] MACRO_SLOT_ZERO,
  input wire logic        PIX_WE,
  input wire logic        FONT_WE,
  input wire logic [4:0]  SCRATCH_HANDLE,
  input wire logic [1:0]  TASK_ACTIVE
);
  import coproc_cmd_pkg::*;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // opcode only counts when no partial command is held
  sequence s_op(logic [31:0] op);
    cmd_valid && cmd_ready && cmd_idle && cmd_word == op;
  endsequence
  sequence s_prm;
    cmd_valid && cmd_ready;
  endsequence
  a_link_ready: assert property (cmd_ready)
    else $error("link refused a word");
  a_idle_after: assert property (s_op(OP_SET_ROTATE) ##1 s_prm |=> cmd_idle)
    else $error("link not idle after rotate");
  a_rotate_copy: assert property (s_op(OP_SET_ROTATE) ##1 s_prm |=>
    ROTATE == $past(cmd_word[2:0])) else $error("rotation not copied");
  a_orient_follow: assert property ($changed(ROTATE) |->
    ##[0:2] TOUCH_ORIENT == ROTATE) else $error("touch orientation lags");
  a_swap_spin: assert property (DL_SWAP |-> ##[0:1] TASK_ACTIVE == TASK_SPIN)
    else $error("swap without spinner");
  a_saver_start: assert property (s_op(OP_SCREENSAVER) |=> TASK_ACTIVE == TASK_SAVER)
    else $error("screensaver not started");
  a_stop_task: assert property (s_op(OP_STOP) |=> TASK_ACTIVE == TASK_NONE)
    else $error("stop left a task");
  a_stop_freeze: assert property (TASK_ACTIVE == TASK_NONE &&
    $past(TASK_ACTIVE) == TASK_NONE |-> $stable(MACRO_SLOT_ZERO))
    else $error("macro slot moved while idle");
  a_pix_sketch: assert property (PIX_WE |-> TASK_ACTIVE == TASK_SKETCH ||
    $past(TASK_ACTIVE) == TASK_SKETCH) else $error("pixel write outside sketch");
  a_font_write: assert property (s_op(OP_SET_FONT) ##1 s_prm[*2] |=> FONT_WE)
    else $error("font not registered");
  a_font_ext: assert property (s_op(OP_SET_FONT_EXT) ##1 s_prm[*3] |=> FONT_WE)
    else $error("extended font not registered");
  a_scratch_set: assert property (s_op(OP_SET_SCRATCH) ##1 s_prm |=>
    SCRATCH_HANDLE == $past(cmd_word[4:0])) else $error("scratch not set");
endmodule : coproc_cmd_monitor

/* File: verification/coproc_rotate_anim_font_cmds_tb.sv */
// host and engine back to back, driven from the user and touch sides
`timescale 1ns/1ps
module coproc_rotate_anim_font_cmds_tb;
  import coproc_cmd_pkg::*;
  localparam int FD = 8;
  localparam int TD = 4;
  logic        MCLK, SYS_RST, req_valid, req_ready, req_done;
  logic [31:0] req_op, p0, p1, p2, p3;
  logic [2:0]  req_n, rotate, orient;
  logic        touch_valid, dl_swap, pix_we, font_we;
  logic [15:0] touch_x, touch_y;
  logic [31:0] slot_zero, slot_one, font_m, font_c;
  logic [31:0] pix_addr, last_addr;
  logic [7:0]  pix_data, last_data;
  logic [4:0]  font_h, scratch;
  logic [1:0]  task_act;
  logic [31:0] words[$];
  int          n_mismatch, checked, n_swap, n_pix, n_font;
  coproc_cmd_if lnk ();
  coproc_cmd_host coproc_cmd_host_i (.MCLK(MCLK), .SYS_RST(SYS_RST), .REQ_VALID(req_valid),
    .REQ_OP(req_op), .REQ_NWORDS(req_n), .REQ_P0(p0), .REQ_P1(p1), .REQ_P2(p2),
    .REQ_P3(p3), .REQ_READY(req_ready), .REQ_DONE(req_done), .CMD(lnk));
  coproc_cmd_engine #(.FRAME_DIV(FD), .TOUCH_DIV(TD)) coproc_cmd_engine_i (.MCLK(MCLK),
    .SYS_RST(SYS_RST), .CMD(lnk), .TOUCH_VALID(touch_valid), .TOUCH_X(touch_x),
    .TOUCH_Y(touch_y), .ROTATE(rotate), .TOUCH_ORIENT(orient), .DL_SWAP(dl_swap),
    .MACRO_SLOT_ZERO(slot_zero), .MACRO_SLOT_ONE(slot_one), .PIX_WE(pix_we),
    .PIX_ADDR(pix_addr), .PIX_DATA(pix_data), .FONT_WE(font_we), .FONT_HANDLE(font_h),
    .FONT_METRICS(font_m), .FONT_FIRST_CHAR(font_c), .SCRATCH_HANDLE(scratch),
    .TASK_ACTIVE(task_act));
  coproc_cmd_monitor coproc_cmd_monitor_i (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .cmd_valid(lnk.cmd_valid), .cmd_word(lnk.cmd_word), .cmd_ready(lnk.cmd_ready),
    .cmd_idle(lnk.cmd_idle), .ROTATE(rotate), .TOUCH_ORIENT(orient), .DL_SWAP(dl_swap),
    .MACRO_SLOT_ZERO(slot_zero), .PIX_WE(pix_we), .FONT_WE(font_we),
    .SCRATCH_HANDLE(scratch), .TASK_ACTIVE(task_act));
  initial
  begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end
  // pre-edge values, so no race with the design's own updates
  always @(posedge MCLK)
  begin
    if (lnk.cmd_valid && lnk.cmd_ready) words.push_back(lnk.cmd_word);
    if (dl_swap) n_swap++;
    if (pix_we)
    begin
      n_pix++;
      last_addr = pix_addr;
      last_data = pix_data;
    end
    if (font_we) n_font++;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic send(input logic [31:0] op, input logic [2:0] n, input logic [31:0] a = 0,
                      input logic [31:0] b = 0, input logic [31:0] c = 0,
                      input logic [31:0] d = 0);
    int k;
    k = 0;
    do
    begin
      @(negedge MCLK);
      k++;
    end while (req_ready !== 1'b1 && k < 50);
    words.delete();
    @(posedge MCLK);
    req_op <= op;
    req_n <= n;
    p0 <= a;
    p1 <= b;
    p2 <= c;
    p3 <= d;
    req_valid <= 1'b1;
    @(posedge MCLK);
    req_valid <= 1'b0;
    k = 0;
    while (req_done !== 1'b1 && k < 50)
    begin
      @(negedge MCLK);
      k++;
    end
    chk("done", 1, req_done);
    chk("nwords", n + 1, words.size());
    chk("opword", op, words[0]);
  endtask : send
  // hold a touch and judge the pixel writes it causes
  task automatic pen(input logic [15:0] x, input logic [15:0] y, input logic e);
    int b;
    @(posedge MCLK);
    touch_x <= x;
    touch_y <= y;
    touch_valid <= 1'b1;
    // let the previous touch drain through the pin flops first
    repeat (4) @(negedge MCLK);
    b = n_pix;
    repeat (6 * TD) @(negedge MCLK);
    chk("pix", e, n_pix != b);
    chk("rate", 1, n_pix - b <= 7);
  endtask : pen
  task automatic stop_chk;
    logic [31:0] v0, v1;
    send(OP_STOP, 3'h0);
    chk("stop", TASK_NONE, task_act);
    v0 = slot_zero;
    v1 = slot_one;
    pen(16'd15, 16'd15, 1'b0);
    chk("slot0", v0, slot_zero);
    chk("slot1", v1, slot_one);
  endtask : stop_chk
  task automatic t_rotate;
    for (int r = 7; r >= 0; r--)
    begin
      send(OP_SET_ROTATE, 3'h1, r);
      chk("rot", r, rotate);
      chk("orient", r, orient);
      chk("param", r, words[1]);
    end
  endtask : t_rotate
  task automatic t_spin;
    int per[4] = '{SPIN_FRAMES_S0, SPIN_FRAMES_S1, SPIN_FRAMES_S2, SPIN_FRAMES_S3};
    logic [31:0] v;
    for (int s = 0; s < 4; s++)
    begin
      send(OP_SPINNER, 3'h2, 32'h0014000a, (s << 16) | s);
      chk("spin", TASK_SPIN, task_act);
      repeat (3) @(negedge MCLK);
      chk("swap", s + 1, n_swap);
      // one frame first, so the slots already hold this spinner
      repeat (FD) @(negedge MCLK);
      v = slot_one;
      repeat (FD) @(negedge MCLK);
      chk("step", 1, slot_one !== v);
      repeat (per[s] * FD - FD) @(negedge MCLK);
      chk("cycle", v, slot_one);
      chk("vertex", {VERTEX_OP, 1'b0, 14'h000a, 1'b0, 14'h0014}, slot_zero);
      chk("scale", (s == 0) ? 1 : s, slot_one[31:16]);
      chk("style", s, slot_one[10:9]);
      send(OP_SET_SCRATCH, 3'h1, 28 + s);
      chk("scratch", 28 + s, scratch);
      chk("alive", TASK_SPIN, task_act);
      stop_chk();
    end
  endtask : t_spin
  task automatic t_saver;
    logic [31:0] v;
    send(OP_SCREENSAVER, 3'h0);
    chk("saver", TASK_SAVER, task_act);
    repeat (2 * FD) @(negedge MCLK);
    v = slot_zero;
    repeat (FD) @(negedge MCLK);
    chk("move", 1, slot_zero !== v);
    chk("vtx", VERTEX_OP, slot_zero[31:30]);
    stop_chk();
  endtask : t_saver
  task automatic t_sketch;
    logic [31:0] fm[2] = '{one_bit_luma_format, eight_bit_luma_format};
    for (int i = 0; i < 2; i++)
    begin
      send(OP_SKETCH, 3'h4, 32'h000a000a, 32'h00140014, 32'h00001000, fm[i]);
      chk("sketch", TASK_SKETCH, task_act);
      pen(16'd15, 16'd15, 1'b1);
      chk("paddr", (i == 1) ? 32'h00001069 : 32'h0000100d, last_addr);
      chk("pdata", (i == 1) ? 8'hff : 8'h40, last_data);
      pen(16'd100, 16'd100, 1'b0);
      stop_chk();
    end
  endtask : t_sketch
  task automatic t_font;
    send(OP_SET_FONT, 3'h2, 7, 1000);
    chk("fh", 7, font_h);
    chk("fm", 1000, font_m);
    send(OP_SET_FONT_EXT, 3'h3, 20, 100000, 32);
    chk("fh2", 20, font_h);
    chk("fm2", 100000, font_m);
    chk("fc", 32, font_c);
    chk("fwe", 2, n_font);
  endtask : t_font
  // reset in mid-run with a task going and a moved scratch handle
  task automatic t_reset;
    send(OP_SCREENSAVER, 3'h0);
    @(posedge MCLK);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(negedge MCLK);
    chk("rst_task", TASK_NONE, task_act);
    chk("rst_scratch", SCRATCH_RESET, scratch);
    chk("rst_ready", 1, req_ready);
    send(OP_SET_SCRATCH, 3'h1, 9);
    chk("scratch9", 9, scratch);
  endtask : t_reset
  task automatic stop_test;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (30000) @(posedge MCLK);
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    SYS_RST = 1'b1;
    {req_valid, req_op, req_n, p0, p1, p2, p3} = '0;
    {touch_valid, touch_x, touch_y} = '0;
    repeat (12) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(negedge MCLK);
    chk("scratch0", SCRATCH_RESET, scratch);
    chk("idle0", TASK_NONE, task_act);
    t_rotate();
    t_spin();
    t_saver();
    t_sketch();
    t_font();
    t_reset();
    stop_test();
  end
endmodule : coproc_rotate_anim_font_cmds_tb
